// *** logic/rpf_fifo.sv ***
/*
  Synchronous FIFO with registered read data and registered ready.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module rpf_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  rpf_stream_if.snk   in_s,
  rpf_stream_if.src   out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic [W-1:0]  dout_reg;
  logic          ovld_reg;
  logic          rdy_reg;
  wire           push;
  wire           load;

  // Accept while not full; refill output register when it frees
  assign push     = in_s.valid && rdy_reg;
  assign load     = (cnt_reg != '0) && (!ovld_reg || out_s.ready);
  assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  assign in_s.ready  = rdy_reg;
  assign out_s.valid = ovld_reg;
  assign out_s.data  = dout_reg;

  // Storage array, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_s.data;
    end
  end

  // Pointers, fill count and output stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_reg   <= '0;
      rp_reg   <= '0;
      cnt_reg  <= '0;
      dout_reg <= '0;
      ovld_reg <= 1'b0;
      rdy_reg  <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != (AW+1)'(DEPTH));
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (load) begin
        dout_reg <= mem[rp_reg];
        rp_reg   <= rp_reg + 1'b1;
        ovld_reg <= 1'b1;
      end else if (out_s.ready) begin
        ovld_reg <= 1'b0;
      end
    end
  end
endmodule

// *** logic/rpf_framer.sv ***
/*
  Packet framer and deframer: transmit buffer, framing, spreading,
  despreading, frame check, link quality and energy detect.
  Assumes host ports are on clk_i; link clock, chip input and energy
  level come from outside and are synchronised here.
*/
`timescale 1ns/10ps
// Summary of operation
// [RL1] Payloads of 0 to 125 bytes; loads beyond 125 are refused.
// [RL2] Transmit four preamble bytes, delimiter byte, then length byte.
// [RL3] Frame check field follows the last payload byte directly.
// [RL4] Receiver recomputes the two-byte check and reports pass or fail.
// [RL5] Receiver finds preamble, delimiter, length, then counts bytes.
// [RL6] Link quality summed over 64 us after delimiter, then held.
// [RL7] One receive-complete pulse only after the whole packet arrived.
// [RL8] Host loads whole packet into buffer first; framer reads buffer.
// [RL9] Energy detect request samples channel energy for the host.
// [RL10] Transmission starts only on an explicit host request.
// [RL11] Transmit-complete pulse after the whole frame has been sent.
// [RL12] Symbols spread to 32 chips, offset I/Q output, despread back.
// [RL13] Host stays off the interface while busy; 144 us warm-up.
// [RL14] Length byte is payload count plus two check bytes.
module rpf_framer #(
  parameter int WARM_CYCLES = rpf_pkg::WARM_CYC,
  parameter int LQI_CYCLES  = rpf_pkg::LQI_WIN_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_valid_i,
  input  wire logic [7:0] load_data_i,
  output logic            load_ready_o,
  input  wire logic       tx_request_i,
  input  wire logic       ed_request_i,
  input  wire logic [7:0] energy_i,
  input  wire logic       link_clk_i,
  input  wire logic       rx_chip_i,
  output logic            tx_i_o,
  output logic            tx_q_o,
  output logic            tx_on_o,
  output logic            tx_done_o,
  output logic            busy_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_done_o,
  output logic            crc_ok_o,
  output logic [7:0]      lqi_o,
  output logic [7:0]      ed_value_o,
  output logic            ed_done_o
);
  import rpf_pkg::*;

  // Chip word of one symbol: rotation by four chips per step
  function automatic logic [31:0] chip_seq(input logic [3:0] sym);
    logic [63:0] dbl;
    dbl = {CHIP_BASE, CHIP_BASE} >> {sym[2:0], 2'b00};
    return dbl[31:0] ^ (sym[3] ? ODD_MASK : 32'h00000000);
  endfunction

  // Population count of a chip word
  function automatic logic [5:0] ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction

  // Best matching symbol with its agreement score
  function automatic logic [9:0] despread(input logic [31:0] v);
    logic [5:0] best;
    logic [5:0] sc;
    logic [3:0] sym;
    best = 6'h00;
    sym  = 4'h0;
    for (int s = 0; s < 16; s++) begin
      sc = ones(~(v ^ chip_seq(4'(s))));
      if (sc > best) begin
        best = sc;
        sym  = 4'(s);
      end
    end
    return {best, sym};
  endfunction

  // One byte through the frame check register, low bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  rpf_stream_if #(.W(DATA_W)) buf_in ();
  rpf_stream_if #(.W(DATA_W)) buf_out ();

  rpf_fifo #(.W(DATA_W), .DEPTH(TXBUF_DEPTH)) u_txbuf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .in_s  (buf_in),
    .out_s (buf_out)
  );

  // Synchronisers; stage 0 feeds only stage 1
  logic [2:0]  lclk_sync_reg;
  logic [1:0]  chip_sync_reg;
  logic [7:0]  en_s1_reg;
  logic [7:0]  en_s2_reg;
  wire         lclk_edge;
  assign lclk_edge = lclk_sync_reg[1] && !lclk_sync_reg[2];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lclk_sync_reg <= 3'h0;
      chip_sync_reg <= 2'h0;
      en_s1_reg     <= 8'h00;
      en_s2_reg     <= 8'h00;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk_i};
      chip_sync_reg <= {chip_sync_reg[0], rx_chip_i};
      en_s1_reg     <= energy_i;
      en_s2_reg     <= en_s1_reg;
    end
  end

  // Transmit side
  rpf_tx_e     tx_state_reg;
  rpf_tx_e     tx_state_next;
  rpf_rx_e     rx_state_reg;
  rpf_rx_e     rx_state_next;
  logic [15:0] warm_cnt_reg;
  logic [7:0]  pos_reg;
  logic [5:0]  chip_idx_reg;
  logic [7:0]  cur_byte_reg;
  logic [6:0]  tx_len_reg;
  logic [6:0]  load_cnt_reg;
  logic [15:0] tx_crc_reg;
  logic        tx_i_reg;
  logic        tx_q_reg;
  logic        tx_on_reg;
  logic        tx_done_reg;
  logic        load_ready_reg;

  wire         push_ok;
  wire         tx_go;
  wire         tx_send;
  wire         tx_byte_end;
  wire         tx_last;
  wire         tx_fetch;
  wire [7:0]   np;
  wire [7:0]   pay_end;
  wire [7:0]   byte_next;
  wire [6:0]   load_cnt_next;
  wire [31:0]  tx_word;
  wire         tx_chip;

  // Buffer loading and transmit sequencing decode
  assign push_ok       = load_valid_i && load_ready_reg && buf_in.ready;
  assign buf_in.valid  = push_ok;                      // see [RL8]
  assign buf_in.data   = load_data_i;
  assign load_cnt_next = tx_go ? 7'h00 : load_cnt_reg + {6'h00, push_ok};
  assign tx_go   = tx_request_i && tx_state_reg == T_IDLE
                   && rx_state_reg == R_HUNT;          // see [RL10]
  assign tx_send     = tx_state_reg == T_SEND;
  assign tx_byte_end = tx_send && lclk_edge && chip_idx_reg == 6'h3F;
  assign pay_end     = POS_PAY + {1'b0, tx_len_reg};
  assign np          = pos_reg + 8'h01;
  assign tx_last     = tx_byte_end && pos_reg == pay_end + 8'h01;
  assign tx_fetch    = tx_byte_end && np >= POS_PAY && np < pay_end;
  assign buf_out.ready = tx_fetch;                     // see [RL8]
  // Next byte on air: preamble, delimiter, length, payload, check
  assign byte_next =
    (np <  PRE_BYTES)   ? PRE_VALUE :                  // see [RL2]
    (np == PRE_BYTES)   ? FRAME_START_DELIMITER :
    (np == POS_LEN)     ? {1'b0, tx_len_reg + CHECK_BYTES} : // see [RL14]
    (np <  pay_end)     ? (buf_out.valid ? buf_out.data : 8'h00) :
    (np == pay_end)     ? tx_crc_reg[7:0] :            // see [RL3]
                          tx_crc_reg[15:8];
  // Chip of current symbol, low nibble first
  assign tx_word = chip_seq(chip_idx_reg[5] ? cur_byte_reg[7:4]
                                            : cur_byte_reg[3:0]);
  assign tx_chip = tx_word[chip_idx_reg[4:0]];         // see [RL12]

  // Transmit state decision
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      T_IDLE: begin
        if (tx_go) begin
          tx_state_next = T_WARM;
        end
      end
      T_WARM: begin
        if (warm_cnt_reg == 16'h0000) begin
          tx_state_next = T_SEND;
        end
      end
      T_SEND: begin
        if (tx_last) begin
          tx_state_next = T_IDLE;
        end
      end
      default: tx_state_next = T_IDLE;
    endcase
  end

  // Transmit registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_reg   <= T_IDLE;
      warm_cnt_reg   <= 16'h0000;
      pos_reg        <= 8'h00;
      chip_idx_reg   <= 6'h00;
      cur_byte_reg   <= 8'h00;
      tx_len_reg     <= 7'h00;
      load_cnt_reg   <= 7'h00;
      tx_crc_reg     <= CRC_INIT;
      tx_i_reg       <= 1'b0;
      tx_q_reg       <= 1'b0;
      tx_on_reg      <= 1'b0;
      tx_done_reg    <= 1'b0;
      load_ready_reg <= 1'b0;
    end else begin
      tx_state_reg   <= tx_state_next;
      load_cnt_reg   <= load_cnt_next;
      tx_on_reg      <= tx_state_next == T_SEND;
      tx_done_reg    <= tx_last;                       // see [RL11]
      load_ready_reg <= tx_state_next == T_IDLE
                        && load_cnt_next != MAX_PAYLOAD; // see [RL1]
      if (tx_go) begin
        tx_len_reg   <= load_cnt_reg;
        warm_cnt_reg <= 16'(WARM_CYCLES - 1);          // see [RL13]
        tx_crc_reg   <= CRC_INIT;
        pos_reg      <= 8'h00;
        chip_idx_reg <= 6'h00;
        cur_byte_reg <= PRE_VALUE;
      end else if (tx_state_reg == T_WARM) begin
        warm_cnt_reg <= warm_cnt_reg - 16'h0001;
      end
      if (tx_send && lclk_edge) begin
        chip_idx_reg <= chip_idx_reg + 6'h01;
        // Even chips on I, odd on Q: Q lags one link clock period
        if (!chip_idx_reg[0]) begin
          tx_i_reg <= tx_chip;                         // see [RL12]
        end else begin
          tx_q_reg <= tx_chip;
        end
      end
      if (tx_byte_end) begin
        pos_reg      <= np;
        cur_byte_reg <= byte_next;
      end
      if (tx_fetch) begin
        tx_crc_reg <= crc_byte(tx_crc_reg, byte_next); // see [RL3]
      end
    end
  end

  // Receive side
  logic [31:0] shreg_reg;
  logic [4:0]  sym_cnt_reg;
  logic        have_lo_reg;
  logic [3:0]  lo_nib_reg;
  logic [6:0]  rx_len_reg;
  logic [6:0]  rx_idx_reg;
  logic [15:0] rx_crc_reg;
  logic [7:0]  chk_lo_reg;
  logic [7:0]  rx_data_reg;
  logic        rx_valid_reg;
  logic        rx_done_reg;
  logic        crc_ok_reg;
  logic        lqi_on_reg;
  logic [15:0] lqi_cnt_reg;
  logic [7:0]  lqi_acc_reg;
  logic [7:0]  lqi_reg;
  logic [7:0]  ed_value_reg;
  logic        ed_done_reg;
  logic        busy_reg;

  wire [31:0]  sh_next;
  wire [9:0]   dec;
  wire [3:0]   sym;
  wire [8:0]   lqi_sum;
  wire         hunt_hit;
  wire         sym_done;
  wire         delim_hit;
  wire         byte_done;
  wire [7:0]   byte_val;
  wire [6:0]   pay_n;
  wire         len_ok;

  // Despreading and byte assembly decode
  assign sh_next  = {chip_sync_reg[1], shreg_reg[31:1]};
  assign dec      = despread(sh_next);                 // see [RL12]
  assign sym      = dec[3:0];
  assign hunt_hit = rx_state_reg == R_HUNT && lclk_edge
                    && tx_state_reg == T_IDLE
                    && ones(sh_next ^ chip_seq(4'h0)) <= PRE_MAX_DIST;
  assign sym_done = lclk_edge && rx_state_reg != R_HUNT
                    && sym_cnt_reg == 5'h1F;
  assign delim_hit = rx_state_reg == R_DELIM && sym_done
                    && lo_nib_reg == FRAME_START_DELIMITER[3:0]
                    && sym == FRAME_START_DELIMITER[7:4]; // see [RL5]
  assign byte_done = sym_done && have_lo_reg;
  assign byte_val  = {sym, lo_nib_reg};
  assign len_ok    = !byte_val[7] && byte_val[6:0] >= CHECK_BYTES
                     && byte_val[6:0] <= MAX_PAYLOAD + CHECK_BYTES;
  assign pay_n     = rx_len_reg - CHECK_BYTES;         // see [RL14]
  assign lqi_sum   = {1'b0, lqi_acc_reg} + {3'h0, dec[9:4]};

  // Receive state decision
  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      R_HUNT: begin
        if (hunt_hit) begin
          rx_state_next = R_DELIM;
        end
      end
      R_DELIM: begin
        if (delim_hit) begin
          rx_state_next = R_LEN;
        end else if (sym_done && sym != 4'h0
                     && sym != FRAME_START_DELIMITER[3:0]) begin
          rx_state_next = R_HUNT;
        end
      end
      R_LEN: begin
        if (byte_done) begin
          rx_state_next = len_ok ? R_DATA : R_HUNT;    // see [RL5]
        end
      end
      R_DATA: begin
        if (byte_done && rx_idx_reg == rx_len_reg - 7'h01) begin
          rx_state_next = R_HUNT;
        end
      end
      default: rx_state_next = R_HUNT;
    endcase
  end

  // Receive registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_reg <= R_HUNT;
      shreg_reg    <= 32'h00000000;
      sym_cnt_reg  <= 5'h00;
      have_lo_reg  <= 1'b0;
      lo_nib_reg   <= 4'h0;
      rx_len_reg   <= 7'h00;
      rx_idx_reg   <= 7'h00;
      rx_crc_reg   <= CRC_INIT;
      chk_lo_reg   <= 8'h00;
      rx_data_reg  <= 8'h00;
      rx_valid_reg <= 1'b0;
      rx_done_reg  <= 1'b0;
      crc_ok_reg   <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_valid_reg <= 1'b0;
      rx_done_reg  <= 1'b0;
      if (lclk_edge) begin
        shreg_reg   <= sh_next;
        sym_cnt_reg <= hunt_hit ? 5'h00 : sym_cnt_reg + 5'h01;
      end
      if (sym_done) begin
        lo_nib_reg  <= have_lo_reg ? lo_nib_reg : sym;
        have_lo_reg <= rx_state_reg != R_DELIM && !have_lo_reg;
      end
      if (sym_done && rx_state_reg == R_DELIM) begin
        lo_nib_reg <= sym;
      end
      if (byte_done && rx_state_reg == R_LEN) begin
        rx_len_reg <= byte_val[6:0];
        rx_idx_reg <= 7'h00;
        rx_crc_reg <= CRC_INIT;
      end
      if (byte_done && rx_state_reg == R_DATA) begin
        rx_idx_reg <= rx_idx_reg + 7'h01;
        if (rx_idx_reg < pay_n) begin
          rx_data_reg  <= byte_val;
          rx_valid_reg <= 1'b1;
          rx_crc_reg   <= crc_byte(rx_crc_reg, byte_val); // see [RL4]
        end else if (rx_idx_reg == pay_n) begin
          chk_lo_reg <= byte_val;
        end else begin
          crc_ok_reg  <= {byte_val, chk_lo_reg} == rx_crc_reg; // see [RL4]
          rx_done_reg <= 1'b1;                         // see [RL7]
        end
      end
    end
  end

  // Link quality window, energy detect and busy flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lqi_on_reg   <= 1'b0;
      lqi_cnt_reg  <= 16'h0000;
      lqi_acc_reg  <= 8'h00;
      lqi_reg      <= 8'h00;
      ed_value_reg <= 8'h00;
      ed_done_reg  <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      ed_done_reg <= ed_request_i;
      busy_reg    <= tx_state_next != T_IDLE || rx_state_next != R_HUNT;
      if (ed_request_i) begin
        ed_value_reg <= en_s2_reg;                     // see [RL9]
      end
      if (delim_hit) begin
        lqi_on_reg  <= 1'b1;                           // see [RL6]
        lqi_cnt_reg <= 16'(LQI_CYCLES - 1);
        lqi_acc_reg <= 8'h00;
      end else if (lqi_on_reg) begin
        lqi_cnt_reg <= lqi_cnt_reg - 16'h0001;
        if (sym_done) begin
          lqi_acc_reg <= lqi_sum[8] ? LQI_MAX : lqi_sum[7:0];
        end
        if (lqi_cnt_reg == 16'h0000) begin
          lqi_on_reg <= 1'b0;
          lqi_reg    <= lqi_acc_reg;                   // see [RL6]
        end
      end
    end
  end

  // Outputs straight from registers
  assign load_ready_o = load_ready_reg;
  assign tx_i_o       = tx_i_reg;
  assign tx_q_o       = tx_q_reg;
  assign tx_on_o      = tx_on_reg;
  assign tx_done_o    = tx_done_reg;
  assign busy_o       = busy_reg;
  assign rx_data_o    = rx_data_reg;
  assign rx_valid_o   = rx_valid_reg;
  assign rx_done_o    = rx_done_reg;
  assign crc_ok_o     = crc_ok_reg;
  assign lqi_o        = lqi_reg;
  assign ed_value_o   = ed_value_reg;
  assign ed_done_o    = ed_done_reg;

  // Checks on framing, sequencing and results
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_load_limit: // see [RL1]
    assert property (load_cnt_reg <= MAX_PAYLOAD)
      else $error("payload count above limit");
  a_load_when_idle: // see [RL8]
    assert property (push_ok |-> tx_state_reg == T_IDLE)
      else $error("buffer loaded during transmit");
  a_tx_start_warm: // see [RL10]
    assert property (tx_go |=> tx_state_reg == T_WARM && !tx_on_reg)
      else $error("transmit did not enter warm-up");
  a_preamble_delim: // see [RL2]
    assert property (tx_byte_end && pos_reg == 8'h03
                     |=> cur_byte_reg == FRAME_START_DELIMITER)
      else $error("delimiter not after four preamble bytes");
  a_length_byte: // see [RL14]
    assert property (tx_send && pos_reg == POS_LEN |->
                     cur_byte_reg == {1'b0, tx_len_reg + CHECK_BYTES})
      else $error("length byte wrong");
  a_fcs_follows: // see [RL3]
    assert property (tx_send && pos_reg == pay_end |->
                     cur_byte_reg == tx_crc_reg[7:0])
      else $error("check field not after payload");
  a_tx_done_end: // see [RL11]
    assert property (tx_last |=> tx_done_reg && tx_state_reg == T_IDLE
                     ##1 !tx_done_reg)
      else $error("completion pulse wrong");
  a_qpsk_offset: // see [RL12]
    assert property (tx_send && lclk_edge && !chip_idx_reg[0]
                     |=> $stable(tx_q_reg))
      else $error("Q changed on an even chip");
  a_len_capture: // see [RL5]
    assert property (rx_state_reg == R_LEN && byte_done && len_ok
                     |=> rx_state_reg == R_DATA
                     && rx_len_reg == $past(byte_val[6:0]))
      else $error("length not captured");
  a_rx_done_once: // see [RL7]
    assert property (rx_done_reg |-> $past(rx_state_reg == R_DATA)
                     && rx_state_reg == R_HUNT)
      else $error("receive done outside packet end");
  a_crc_result: // see [RL4]
    assert property (rx_done_reg |-> crc_ok_reg ==
                     ($past({byte_val, chk_lo_reg}) == $past(rx_crc_reg)))
      else $error("check result wrong");
  a_lqi_hold: // see [RL6]
    assert property ($changed(lqi_reg) |->
                     $past(lqi_on_reg && lqi_cnt_reg == 16'h0000))
      else $error("link quality changed outside window end");
  a_ed_sample: // see [RL9]
    assert property (ed_request_i |=> ed_done_reg
                     && ed_value_o == $past(en_s2_reg))
      else $error("energy value not sampled");
endmodule

// *** logic/rpf_pkg.sv ***
/*
  Constants, state types and timing figures shared by the packet framer.
  Assumes a 200 MHz core clock; all time figures are converted here.
*/
package rpf_pkg;
  // Core clock rate and documented time figures
  localparam int CLK_MHZ     = 200;
  localparam int LQI_WIN_NS  = 64000;
  localparam int WARM_NS     = 144000;
  // Link quality window, rounded down to whole cycles
  localparam int LQI_WIN_CYC = (LQI_WIN_NS * CLK_MHZ) / 1000;
  // Idle to transmit warm-up, rounded up to whole cycles
  localparam int WARM_CYC    = (WARM_NS * CLK_MHZ + 999) / 1000;

  // Frame layout
  localparam logic [6:0]  MAX_PAYLOAD           = 7'h7D;
  localparam logic [6:0]  CHECK_BYTES           = 7'h02;
  localparam logic [7:0]  PRE_BYTES             = 8'h04;
  localparam logic [7:0]  POS_LEN               = 8'h05;
  localparam logic [7:0]  POS_PAY               = 8'h06;
  localparam logic [7:0]  FRAME_START_DELIMITER = 8'hA7;
  localparam logic [7:0]  PRE_VALUE             = 8'h00;

  // Frame check field: reflected 16-bit polynomial, zero seed
  localparam logic [15:0] CRC_INIT              = 16'h0000;
  localparam logic [15:0] CRC_POLY              = 16'h8408;

  // Spreading: base chip word, odd-chip flip for upper eight symbols
  localparam logic [31:0] CHIP_BASE             = 32'h744AC39B;
  localparam logic [31:0] ODD_MASK              = 32'hAAAAAAAA;
  localparam logic [5:0]  PRE_MAX_DIST          = 6'h02;
  localparam logic [7:0]  LQI_MAX               = 8'hFF;

  // Transmit buffer geometry
  localparam int          DATA_W                = 8;
  localparam int          TXBUF_DEPTH           = 128;

  typedef enum {T_IDLE, T_WARM, T_SEND} rpf_tx_e;
  typedef enum {R_HUNT, R_DELIM, R_LEN, R_DATA} rpf_rx_e;
endpackage

// *** logic/rpf_stream_if.sv ***
/*
  Valid/ready byte stream between the framer and its transmit buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface rpf_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// *** testbench/rpf_radio_model.sv ***
/*
  Radio side model: link clock and spread chip stream for the receiver.
  Assumes the framer samples chips on link clock rising edges.
*/
`timescale 1ns/10ps
module rpf_radio_model (
  output logic link_clk_o,
  output logic chip_o
);
  import rpf_pkg::*;
  initial begin
    link_clk_o = 1'b0;
    chip_o     = 1'b0;
  end
  // One 160 ns link period, chip set while the clock is low
  task automatic tick(input logic c);
    chip_o = c;
    #80 link_clk_o = 1'b1;
    #80 link_clk_o = 1'b0;
  endtask
  // Free running periods for transmit, chip line never holds still
  task automatic clocks(input int n);
    repeat (n) tick(~chip_o);
  endtask
  // Spread one symbol, chip 0 first
  task automatic symbol(input logic [3:0] s);
    logic [63:0] w;
    logic [31:0] c;
    w = {CHIP_BASE, CHIP_BASE} >> (4 * s[2:0]);
    c = w[31:0] ^ (s[3] ? ODD_MASK : 32'h00000000);
    for (int k = 0; k < 32; k++) tick(c[k]);
  endtask
  // Low nibble first
  task automatic send_byte(input logic [7:0] b);
    symbol(b[3:0]);
    symbol(b[7:4]);
  endtask
  // Whole frame; bad spoils the check field
  task automatic send(input logic [7:0] pl[$], input logic bad);
    logic [15:0] crc;
    crc = CRC_INIT;
    repeat (4) send_byte(PRE_VALUE);
    send_byte(FRAME_START_DELIMITER);
    send_byte(8'(pl.size()) + 8'h02);
    foreach (pl[i]) begin
      send_byte(pl[i]);
      crc = crc ^ {8'h00, pl[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
    end
    if (bad) crc = ~crc;
    send_byte(crc[7:0]);
    send_byte(crc[15:8]);
    chip_o = ~chip_o;
  endtask
endmodule

// *** testbench/tb.sv ***
/*
  Self-checking bench for the packet framer.
  Assumes the radio model drives link clock and chips.
*/
`timescale 1ns/10ps
module tb;
  import rpf_pkg::*;
  localparam int WARM = 20;
  logic clk_i = 0, rst_i = 1, load_valid_i = 0, tx_request_i = 0;
  logic ed_request_i = 0, load_ready_o, tx_on_o, tx_done_o, busy_o;
  logic [7:0] load_data_i = 0, energy_i = 0, rx_data_o, lqi_o, ed_value_o;
  logic rx_valid_o, rx_done_o, crc_ok_o, ed_done_o, link_clk, chip, ok;
  logic tx_i, tx_q;
  logic [31:0] txw;
  int txk;
  logic [7:0] rxq[$];
  int err_total = 0, check_count = 0, dones = 0, n;
  rpf_framer #(.WARM_CYCLES(WARM), .LQI_CYCLES(4000)) rpf_framer_i (
    .clk_i(clk_i), .rst_i(rst_i), .load_valid_i(load_valid_i),
    .load_data_i(load_data_i), .load_ready_o(load_ready_o),
    .tx_request_i(tx_request_i), .ed_request_i(ed_request_i),
    .energy_i(energy_i), .link_clk_i(link_clk), .rx_chip_i(chip),
    .tx_i_o(tx_i), .tx_q_o(tx_q), .tx_on_o(tx_on_o),
    .tx_done_o(tx_done_o),
    .busy_o(busy_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_done_o(rx_done_o), .crc_ok_o(crc_ok_o), .lqi_o(lqi_o),
    .ed_value_o(ed_value_o), .ed_done_o(ed_done_o));
  rpf_radio_model rpf_radio_model_i (.link_clk_o(link_clk), .chip_o(chip));
  always #2.5 clk_i = ~clk_i;
  // Gather the first 32 sent chips: even ones on I, odd ones on Q
  always @(negedge link_clk) begin
    if (tx_on_o === 1'b1 && txk < 32) begin
      txw = {txk[0] ? tx_q : tx_i, txw[31:1]};
      txk++;
    end
  end
  // Collect received bytes and packet ends
  always @(negedge clk_i) begin
    if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
    if (rx_done_o === 1'b1) begin
      dones++;
      ok = crc_ok_o;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Offer one byte and wait until it is taken
  task automatic load(input logic [7:0] b);
    int w = 0;
    load_valid_i <= 1'b1;
    load_data_i  <= b;
    @(negedge clk_i);
    while (load_ready_o !== 1'b1 && w < 50) begin
      w++;
      @(negedge clk_i);
    end
    chk(16'(w < 50), 16'h0001);
    @(posedge clk_i);
  endtask
  task automatic t_ed;
    energy_i <= 8'h5C;
    repeat (4) @(posedge clk_i);
    ed_request_i <= 1'b1;
    @(posedge clk_i);
    ed_request_i <= 1'b0;
    @(negedge clk_i);
    chk(16'(ed_done_o), 16'h0001);
    chk(16'(ed_value_o), 16'h005C);
    $display("energy detect test done");
  endtask
  task automatic t_rx(input logic [7:0] pl[$], input logic bad);
    rxq.delete();
    n = dones;
    rpf_radio_model_i.send(pl, bad);
    repeat (200) @(negedge clk_i);
    chk(16'(dones - n), 16'h0001);
    chk(16'(ok), 16'(!bad));
    chk(16'(rxq.size()), 16'(pl.size()));
    foreach (pl[i]) chk(16'(rxq[i]), 16'(pl[i]));
    chk(16'(lqi_o != 8'h00), 16'h0001);
    $display("receive test done");
  endtask
  task automatic t_tx;
    @(posedge clk_i);
    load(8'h3C);
    load_valid_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk(16'(tx_on_o), 16'h0000);
    @(posedge clk_i);
    tx_request_i <= 1'b1;
    @(posedge clk_i);
    tx_request_i <= 1'b0;
    @(negedge clk_i);
    chk(16'({busy_o, load_ready_o}), 16'h0002);
    for (n = 1; tx_on_o !== 1'b1 && n < 40; n++) @(negedge clk_i);
    chk(16'(n > WARM && n < WARM + 5), 16'h0001);
    fork
      rpf_radio_model_i.clocks(600);
    join_none
    for (n = 0; tx_on_o === 1'b1 && n < 30000; n++) @(negedge clk_i);
    chk(16'((n + 32) / 64), 16'(32 * (1 + 8)));
    chk(16'(tx_done_o), 16'h0001);
    chk(txw[15:0], CHIP_BASE[15:0]);
    chk(txw[31:16], CHIP_BASE[31:16]);
    wait fork;
    chk(16'({busy_o, load_ready_o}), 16'h0001);
    $display("transmit test done");
  endtask
  task automatic t_full;
    @(posedge clk_i);
    repeat (125) load(8'hA5);
    load_valid_i <= 1'b0;
    @(negedge clk_i);
    chk(16'(load_ready_o), 16'h0000);
    $display("buffer full test done");
  endtask
  initial begin
    #450000;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_ed();
    t_rx('{8'h12, 8'h34, 8'hC5}, 1'b0);
    t_rx('{8'h7E}, 1'b1);
    t_tx();
    t_full();
    report_and_stop();
  end
endmodule
